// File: tlf_cfg.svh
// offsets, field positions and reset values of the tx lane flag bank
`ifndef TLF_CFG_SVH
`define TLF_CFG_SVH

// apb geometry: word index = paddr[11:2], byte address = 4 * index
`define TLF_ADDR_W 12
`define TLF_IDX_W 10
`define TLF_DATA_W 32
`define TLF_LANES 8
`define TLF_GROUPS 6

// latched flag bytes, read only clear on read (word indices)
`define TLF_IDX_TX_FAILURE 10'h087
`define TLF_IDX_TX_INPUT_LOSS 10'h088
`define TLF_IDX_TX_LOCK_LOSS 10'h089
`define TLF_IDX_TX_EQUALISER_FAIL 10'h08a
`define TLF_IDX_TX_POWER_HIGH_ALARM 10'h08b
`define TLF_IDX_TX_POWER_LOW_ALARM 10'h08c

// mask bytes, one per flag byte, read/write (word indices)
`define TLF_IDX_MASK_BASE 10'h0a0
// advertisement byte, read only
`define TLF_IDX_ADVERT 10'h0a8
// live condition bytes, one per flag byte, read only
`define TLF_IDX_LIVE_BASE 10'h0b0

// advertisement bit positions
`define TLF_ADV_TX_FAILURE 0
`define TLF_ADV_TX_INPUT_LOSS 1
`define TLF_ADV_TX_LOCK_LOSS 2
`define TLF_ADV_TX_EQUALISER_FAIL 3
`define TLF_ADV_TX_POWER_ALARM 4
`define TLF_ADV_W 5
`define TLF_ADV_DEFAULT 5'h1f

// reset values
`define TLF_FLAG_RESET 8'h00
`define TLF_MASK_RESET 8'h00
`define TLF_SYNC_RESET 1'b0

`endif

// File: tlf_pkg.sv
// types shared by the tx lane flag bank
package tlf_pkg;

  typedef logic [7:0] tlf_byte_type;

  // per lane raw conditions, one byte per flag group; group 0 in low bits
  typedef struct packed {
    tlf_byte_type tx_power_low_alarm_flag;
    tlf_byte_type tx_power_high_alarm_flag;
    tlf_byte_type tx_equaliser_fail_flag;
    tlf_byte_type tx_lock_loss_flag;
    tlf_byte_type tx_input_loss_flag;
    tlf_byte_type tx_failure_flag;
  } tlf_lanes_type;

  // register classes reached by the apb decode
  typedef enum logic [4:0] {
    TLF_SEL_NONE = 5'b00001,
    TLF_SEL_FLAG = 5'b00010,
    TLF_SEL_MASK = 5'b00100,
    TLF_SEL_ADV = 5'b01000,
    TLF_SEL_LIVE = 5'b10000
  } tlf_sel_type;

endpackage

// File: tlf_sync.sv
// three flop synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ns
`include "tlf_cfg.svh"

module tlf_sync #(
  parameter int W = 48
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] async_in, // levels from outside the domain
  output logic [W-1:0] sync_q // filtered level
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      logic out_d;

      // a change counts only when the second and third stage agree
      always_comb
      begin
        out_d = (s2_q == s3_q) ? s2_q : out_q;
      end

      // stage registers; first stage feeds only the second
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q <= `TLF_SYNC_RESET;
          s2_q <= `TLF_SYNC_RESET;
          s3_q <= `TLF_SYNC_RESET;
          out_q <= `TLF_SYNC_RESET;
        end
        else
        begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          out_q <= out_d;
        end
      end

      assign sync_q[i] = out_q;
    end
  endgenerate

endmodule // tlf_sync

// File: tlf_flag_byte.sv
// one byte of latched per lane flags, cleared when read
`timescale 1ns/1ns
`include "tlf_cfg.svh"

module tlf_flag_byte #(
  parameter int LANES = 8
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic supported, // group is advertised
  input wire logic [LANES-1:0] cond, // live condition per lane
  input wire logic rd_clear, // host read of this byte completes
  output logic [LANES-1:0] flags_q // latched flags
);

  logic [LANES-1:0] flag_q;
  logic [LANES-1:0] flag_d;

  // latch events; a set in the clearing cycle wins over the clear
  always_comb
  begin
    if (!supported)
    begin
      flag_d = '0;
    end
    else
    begin
      flag_d = (flag_q & ~{LANES{rd_clear}}) | cond;
    end
  end

  // flag storage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= LANES'(`TLF_FLAG_RESET);
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  assign flags_q = flag_q;

endmodule // tlf_flag_byte

// File: tlf_flags.sv
// tx lane latched flag bank with apb register access
`timescale 1ns/1ns
`include "tlf_cfg.svh"

module tlf_flags #(
  parameter int LANES = `TLF_LANES,
  parameter logic [`TLF_ADV_W-1:0] ADVERT = `TLF_ADV_DEFAULT
) (
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [`TLF_ADDR_W-1:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [`TLF_DATA_W-1:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [`TLF_DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input tlf_pkg::tlf_lanes_type tx_cond, // raw per lane conditions
  output logic flag_pending // some unmasked flag is set
);

  localparam int G = `TLF_GROUPS;

  // synchronised conditions, one byte per group
  tlf_pkg::tlf_lanes_type cond_sync;
  logic [G-1:0][7:0] cond_arr;
  logic [G-1:0][LANES-1:0] flags;
  logic [G-1:0] supported;
  logic [G-1:0] rd_clear;
  logic [G-1:0][LANES-1:0] next_set;

  // mask bytes
  logic [G-1:0][7:0] mask_q;
  logic [G-1:0][7:0] mask_d;

  // bus answer registers
  logic [`TLF_DATA_W-1:0] rdata_q;
  logic [`TLF_DATA_W-1:0] rdata_d;
  logic ready_q;
  logic ready_d;
  logic err_q;
  logic err_d;
  logic pending_q;
  logic pending_d;

  // decode results
  logic [`TLF_IDX_W-1:0] idx;
  logic [`TLF_IDX_W-1:0] flag_off;
  logic [`TLF_IDX_W-1:0] mask_off;
  logic [`TLF_IDX_W-1:0] live_off;
  tlf_pkg::tlf_sel_type sel;
  logic [2:0] grp;
  tlf_pkg::tlf_sel_type sel_q;
  tlf_pkg::tlf_sel_type sel_d;
  logic [2:0] grp_q;
  logic [2:0] grp_d;
  logic setup;
  logic access_done;

  // level inputs come from outside the clock domain
  tlf_sync #(
    .W(G * 8)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(tx_cond),
    .sync_q(cond_sync)
  );

  assign cond_arr = cond_sync;

  // advertisement bit of each group; both power alarms share one bit
  always_comb
  begin
    supported = '0;
    supported[0] = ADVERT[`TLF_ADV_TX_FAILURE];
    supported[1] = ADVERT[`TLF_ADV_TX_INPUT_LOSS];
    supported[2] = ADVERT[`TLF_ADV_TX_LOCK_LOSS];
    supported[3] = ADVERT[`TLF_ADV_TX_EQUALISER_FAIL];
    supported[4] = ADVERT[`TLF_ADV_TX_POWER_ALARM];
    supported[5] = ADVERT[`TLF_ADV_TX_POWER_ALARM];
  end

  // one latched flag byte per group, lane n in bit n-1
  genvar g;
  generate
    for (g = 0; g < G; g = g + 1)
    begin : g_grp
      tlf_flag_byte #(
        .LANES(LANES)
      ) u_byte (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .supported(supported[g]),
        .cond(cond_arr[g][LANES-1:0]),
        .rd_clear(rd_clear[g]),
        .flags_q(flags[g])
      );

      // bits that latch at the coming edge while no clear is due
      assign next_set[g] = supported[g] ? cond_arr[g][LANES-1:0] : '0;
    end
  endgenerate

  // word index and offsets into each register class
  always_comb
  begin
    idx = paddr[`TLF_ADDR_W-1:2];
    flag_off = idx - `TLF_IDX_TX_FAILURE;
    mask_off = idx - `TLF_IDX_MASK_BASE;
    live_off = idx - `TLF_IDX_LIVE_BASE;
  end

  // classify the addressed register
  always_comb
  begin
    sel = tlf_pkg::TLF_SEL_NONE;
    grp = 3'h0;
    if (flag_off < 10'(G))
    begin
      sel = tlf_pkg::TLF_SEL_FLAG;
      grp = flag_off[2:0];
    end
    else if (mask_off < 10'(G))
    begin
      sel = tlf_pkg::TLF_SEL_MASK;
      grp = mask_off[2:0];
    end
    else if (idx == `TLF_IDX_ADVERT)
    begin
      sel = tlf_pkg::TLF_SEL_ADV;
    end
    else if (live_off < 10'(G))
    begin
      sel = tlf_pkg::TLF_SEL_LIVE;
      grp = live_off[2:0];
    end
  end

  // setup phase is where the answer is prepared
  always_comb
  begin
    setup = psel & ~penable;
    access_done = psel & penable & ready_q;
  end

  // keep the setup decode, so the access acts on the byte reported
  always_comb
  begin
    sel_d = sel_q;
    grp_d = grp_q;
    if (setup)
    begin
      sel_d = sel;
      grp_d = grp;
    end
  end

  // read data and error are registered during setup
  always_comb
  begin
    rdata_d = rdata_q;
    err_d = err_q;
    if (setup)
    begin
      rdata_d = '0;
      err_d = 1'b0;
      case (sel)
        tlf_pkg::TLF_SEL_FLAG:
        begin
          // bits latching at this edge are reported too, so the clear
          // at the end of the access never drops an unreported event
          rdata_d[LANES-1:0] = flags[grp] | next_set[grp];
          err_d = pwrite; // flag bytes are read only
        end
        tlf_pkg::TLF_SEL_MASK:
        begin
          rdata_d[7:0] = mask_q[grp];
        end
        tlf_pkg::TLF_SEL_ADV:
        begin
          rdata_d[`TLF_ADV_W-1:0] = ADVERT;
          err_d = pwrite;
        end
        tlf_pkg::TLF_SEL_LIVE:
        begin
          rdata_d[7:0] = supported[grp] ? cond_arr[grp] : 8'h00;
          err_d = pwrite;
        end
        default:
        begin
          err_d = 1'b1; // unmapped address
        end
      endcase
    end
  end

  // no wait state: ready rises in the first access cycle after setup
  always_comb
  begin
    ready_d = setup;
  end

  // a completed read of a flag byte clears it
  always_comb
  begin
    rd_clear = '0;
    if (access_done && !pwrite && sel_q == tlf_pkg::TLF_SEL_FLAG)
    begin
      rd_clear[grp_q] = 1'b1;
    end
  end

  // mask writes take effect at the completing edge, lane 0 strobe
  always_comb
  begin
    mask_d = mask_q;
    if (access_done && pwrite && sel_q == tlf_pkg::TLF_SEL_MASK
        && pstrb[0])
    begin
      mask_d[grp_q] = pwdata[7:0];
    end
  end

  // any flag whose mask bit is clear raises the pending level
  always_comb
  begin
    pending_d = 1'b0;
    for (int k = 0; k < G; k++)
    begin
      pending_d = pending_d | (|(flags[k] & ~mask_q[k][LANES-1:0]));
    end
  end

  // read data and error registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // ready register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= ready_d;
    end
  end

  // decode registers, loaded at setup
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= tlf_pkg::TLF_SEL_NONE;
      grp_q <= 3'h0;
    end
    else
    begin
      sel_q <= sel_d;
      grp_q <= grp_d;
    end
  end

  // mask registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= {G{`TLF_MASK_RESET}};
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // pending register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pending_q <= 1'b0;
    end
    else
    begin
      pending_q <= pending_d;
    end
  end

  // outputs straight from flops
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign flag_pending = pending_q;

endmodule // tlf_flags

// File: tlf_host_model.sv
// apb host model, one register transfer per request
`timescale 1ns/1ns

module tlf_host_model (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic go, // start
  input wire logic wr, // write
  input wire logic [9:0] idx, // word index
  input wire logic [7:0] wd, // data
  input wire logic pready, // ready
  output logic [11:0] paddr, // address
  output logic psel, // select
  output logic penable, // access
  output logic pwrite, // direction
  output logic [31:0] pwdata // data
);
  // setup cycle, then access held until pready
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= 12'h000;
      pwrite <= 1'b0;
      pwdata <= 32'h00000000;
    end
    else if (psel && penable && pready)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
    else if (psel)
      penable <= 1'b1;
    else if (go)
    begin
      psel <= 1'b1;
      paddr <= {idx, 2'b00};
      pwrite <= wr;
      pwdata <= {24'h0, wd};
    end
endmodule // tlf_host_model

// File: tlf_flags_props.sv
// assertions for the tx lane flag bank
`timescale 1ns/1ns

module tlf_flags_props #(
  parameter int LANES = 8,
  parameter logic [4:0] ADVERT = 5'h1f
) (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [11:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [31:0] prdata, // data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input tlf_pkg::tlf_lanes_type tx_cond // conditions
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] idx;
  // word index of the bus address
  assign idx = paddr[11:2];
  // steps of a read of the failure byte
  sequence s_rd_setup;
    psel && !penable && !pwrite && idx == 10'h087;
  endsequence
  sequence s_rd_done;
    pready && !pwrite && idx == 10'h087;
  endsequence
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("no ready");
  property p_rdy1;
    pready |=> !pready;
  endproperty
  a_rdy1: assert property (p_rdy1)
    else $error("long ready");
  property p_ro;
    pready && pwrite && idx >= 10'h087 && idx <= 10'h08c |-> pslverr;
  endproperty
  a_ro: assert property (p_ro)
    else $error("flag write taken");
  property p_unmap;
    pready && idx == 10'h3ff |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped");
  property p_adv;
    pready && !pwrite && idx == 10'h0a8 |-> prdata == {27'h0, ADVERT};
  endproperty
  a_adv: assert property (p_adv)
    else $error("advert");
  property p_set;
    (ADVERT[0] && tx_cond.tx_failure_flag[0]) [*6] ##0 s_rd_setup
      |=> pready && prdata[0];
  endproperty
  a_set: assert property (p_set)
    else $error("flag not set");
  property p_clr;
    (tx_cond.tx_failure_flag == 8'h00) [*6] ##0 s_rd_done ##[1:4] s_rd_setup
      |=> prdata[7:0] == 8'h00;
  endproperty
  a_clr: assert property (p_clr)
    else $error("flag not cleared");
  property p_unadv;
    pready && !pwrite && idx == 10'h08a && !ADVERT[3] |-> prdata == 32'h0;
  endproperty
  a_unadv: assert property (p_unadv)
    else $error("unadvertised set");
endmodule // tlf_flags_props

bind tlf_flags tlf_flags_props #(.LANES(LANES), .ADVERT(ADVERT)) u_props (
  .ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .tx_cond);

// File: tb_top.sv
// self-checking bench for the tx lane flag bank
`timescale 1ns/1ns

module tb_top;
  localparam logic [4:0] ADV = 5'h17;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [9:0] idx = 10'h000;
  logic [7:0] wd = 8'h00;
  logic [3:0] strb = 4'hf;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, flag_pending;
  logic [31:0] pwdata, prdata;
  tlf_pkg::tlf_lanes_type cond = '0;
  logic [9:0] q[$];
  logic [9:0] e, x;
  logic [7:0] pat;
  int miscompares = 0;
  int compares = 0;

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  tlf_flags #(.LANES(8), .ADVERT(ADV)) dut (.ref_clk, .rst_n, .paddr,
    .psel, .penable, .pwrite, .pwdata, .pstrb(strb), .prdata, .pready,
    .pslverr, .tx_cond(cond), .flag_pending);
  tlf_host_model host (.ref_clk, .rst_n, .go, .wr, .idx, .wd, .pready,
    .paddr, .psel, .penable, .pwrite, .pwdata);

  task automatic check(input string nm, input logic [8:0] ex, got);
    compares++;
    if (got !== ex)
    begin
      miscompares++;
      $display("ERROR %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic end_sim();
    miscompares += q.size();
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one transfer; ex is {check data, error, data}
  task automatic xfer(input logic w, input logic [9:0] i,
    input logic [9:0] ex);
    int n;
    q.push_back(ex);
    wr <= w;
    idx <= i;
    wd <= ex[7:0];
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (psel !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      end_sim();
    end
    @(posedge ref_clk);
  endtask

  // compare each answered transfer with the oldest note
  always @(negedge ref_clk)
    if (pready === 1'b1)
    begin
      e = q.pop_front();
      check("apb", e[8:0], {pslverr, e[9] ? prdata[7:0] : e[7:0]});
      if (e[9])
        check("upper", 9'h000, 9'(|prdata[31:8]));
    end

  // per group set, hold, clear; then masks and refusals
  initial
  begin
    void'($urandom(33));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int g = 0; g < 6; g++)
    begin
      pat = 8'($urandom) | 8'h01;
      x = (g == 3) ? 10'h200 : {2'b10, pat};
      cond[g*8 +: 8] <= pat;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      check("pending", {8'h00, g != 3}, {8'h00, flag_pending});
      @(posedge ref_clk);
      xfer(1'b0, 10'(10'h087 + g), x);
      xfer(1'b0, 10'(10'h087 + g), x);
      cond[g*8 +: 8] <= 8'h00;
      repeat (6) @(posedge ref_clk);
      xfer(1'b0, 10'(10'h087 + g), x);
      xfer(1'b0, 10'(10'h087 + g), 10'h200);
    end
    xfer(1'b1, 10'h0a0, 10'h0ff);
    cond[7:0] <= 8'h81;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check("pending", 9'h000, {8'h00, flag_pending});
    @(posedge ref_clk);
    xfer(1'b0, 10'h0a0, 10'h2ff);
    xfer(1'b1, 10'h087, 10'h100);
    xfer(1'b0, 10'h087, 10'h281);
    xfer(1'b0, 10'h3ff, 10'h300);
    xfer(1'b0, 10'h0a8, {5'h10, ADV});
    xfer(1'b0, 10'h0b0, 10'h281);
    xfer(1'b1, 10'h0b0, 10'h100);
    strb <= 4'h0;
    xfer(1'b1, 10'h0a1, 10'h055);
    strb <= 4'hf;
    xfer(1'b0, 10'h0a1, 10'h200);
    end_sim();
  end
endmodule // tb_top
